// ### rtl/blit_geometry_alpha_regs.sv
// Blit geometry and window alpha register bank with AXI4-Lite slave
//
// Behaviour
// - Second source image width is held as bits 12..2 from the low byte 7..2 and high byte 4..0.
// - Second source corner X and Y are 13 bits, low byte 7..0 and high byte 4..0.
// - Destination start address is 32 bits, bytes low first, bits 1..0 fixed at zero.
// - Destination image width is bits 12..2 and must be a multiple of four.
// - Destination corner X and Y are 13 bits, low byte 7..0 and high byte 4..0.
// - Transfer window width is a 13-bit pixel count.
// - Transfer window height is a 13-bit pixel count, upper high-byte bits unused.
// - With pattern fill on, window width and height become a fixed 8 or 16.
// - Alpha codes 00h to 1Fh mean code/32 and any code 2Xh means one.
// - Each mixed pixel is first source times one minus alpha plus second times alpha.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "blit_geometry_alpha_defs.svh"
module blit_geometry_alpha_regs
	import blit_regs_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [11:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [11:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic [23:0] first_source_pixel_i,
	input  wire logic [23:0] second_source_pixel_i,
	output logic [23:0]      blended_pixel_o,
	output logic [12:0]      second_source_image_width_o,
	output logic [12:0]      second_source_corner_x_o,
	output logic [12:0]      second_source_corner_y_o,
	output logic [31:0]      destination_start_address_o,
	output logic [12:0]      destination_image_width_o,
	output logic [12:0]      destination_corner_x_o,
	output logic [12:0]      destination_corner_y_o,
	output logic [12:0]      transfer_window_width_o,
	output logic [12:0]      transfer_window_height_o,
	output logic [5:0]       alpha_level_o
);

	bank_s       st;
	bank_s       next_st;
	alpha_mix_if mix_bus ();

	logic        aw_fire;
	logic        w_fire;
	logic        ar_fire;
	logic        have_aw;
	logic        have_w;
	logic [9:0]  wr_idx;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [9:0]  rd_idx;

	// ======================================================================
	// Helpers
	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Merge for a 13-bit field under a mask
	function automatic logic [12:0] merge13(input logic [12:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [12:0] mask);
		logic [31:0] full;
		full = merge({19'h00000, old}, wd, strb);
		return full[12:0] & mask;
	endfunction

	// ======================================================================
	// Handshakes
	assign aw_fire = s_axi_awvalid_i && st.aw_ready;
	assign w_fire  = s_axi_wvalid_i && st.w_ready;
	assign ar_fire = s_axi_arvalid_i && st.ar_ready;
	assign have_aw = aw_fire || st.aw_held;
	assign have_w  = w_fire || st.w_held;
	assign wr_idx  = aw_fire ? s_axi_awaddr_i[11:2] : st.aw_idx;
	assign wr_data = w_fire ? s_axi_wdata_i : st.w_data;
	assign wr_strb = w_fire ? s_axi_wstrb_i : st.w_strb;
	assign rd_idx  = s_axi_araddr_i[11:2];

	// ======================================================================
	// Next state
	always_comb begin
		next_st = st;
		// Hold whichever of address and data came first
		if (aw_fire) begin
			next_st.aw_held = 1'b1;
			next_st.aw_idx  = s_axi_awaddr_i[11:2];
		end
		if (w_fire) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata_i;
			next_st.w_strb = s_axi_wstrb_i;
		end
		if (st.bvalid && s_axi_bready_i) begin
			next_st.bvalid = 1'b0;
		end
		// Register write once both halves are present
		if (have_aw && have_w && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = `RESP_OKAY;
			unique case (wr_idx)
				`IDX_SRC2_WIDTH: next_st.src2_width = merge13(st.src2_width, wr_data,
					wr_strb, `MASK_WIDTH);
				`IDX_SRC2_X: next_st.src2_x = merge13(st.src2_x, wr_data, wr_strb,
					`MASK_COORD);
				`IDX_SRC2_Y: next_st.src2_y = merge13(st.src2_y, wr_data, wr_strb,
					`MASK_COORD);
				`IDX_DST_ADDR: next_st.dst_addr = merge(st.dst_addr, wr_data, wr_strb)
					& `MASK_ADDR;
				`IDX_DST_WIDTH: next_st.dst_width = merge13(st.dst_width, wr_data,
					wr_strb, `MASK_WIDTH);
				`IDX_DST_X: next_st.dst_x = merge13(st.dst_x, wr_data, wr_strb,
					`MASK_COORD);
				`IDX_DST_Y: next_st.dst_y = merge13(st.dst_y, wr_data, wr_strb,
					`MASK_COORD);
				`IDX_WIN_WIDTH: next_st.win_width = merge13(st.win_width, wr_data,
					wr_strb, `MASK_COORD);
				`IDX_WIN_HEIGHT: next_st.win_height = merge13(st.win_height, wr_data,
					wr_strb, `MASK_COORD);
				`IDX_ALPHA: begin
					if (wr_strb[0]) begin
						next_st.alpha = wr_data[5:0] & `MASK_ALPHA;
					end
				end
				`IDX_FILL_CTRL: begin
					if (wr_strb[0]) begin
						next_st.fill_ctrl = wr_data[1:0] & `MASK_CTRL;
					end
				end
				`IDX_EFF_SIZE: next_st.bresp = `RESP_OKAY;
				default: next_st.bresp = `RESP_SLVERR;
			endcase
		end
		// Read answer
		if (st.rvalid && s_axi_rready_i) begin
			next_st.rvalid = 1'b0;
		end
		if (ar_fire) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = `RESP_OKAY;
			unique case (rd_idx)
				`IDX_SRC2_WIDTH: next_st.rdata = {19'h00000, st.src2_width};
				`IDX_SRC2_X:     next_st.rdata = {19'h00000, st.src2_x};
				`IDX_SRC2_Y:     next_st.rdata = {19'h00000, st.src2_y};
				`IDX_DST_ADDR:   next_st.rdata = st.dst_addr;
				`IDX_DST_WIDTH:  next_st.rdata = {19'h00000, st.dst_width};
				`IDX_DST_X:      next_st.rdata = {19'h00000, st.dst_x};
				`IDX_DST_Y:      next_st.rdata = {19'h00000, st.dst_y};
				`IDX_WIN_WIDTH:  next_st.rdata = {19'h00000, st.win_width};
				`IDX_WIN_HEIGHT: next_st.rdata = {19'h00000, st.win_height};
				`IDX_ALPHA:      next_st.rdata = {26'h0000000, st.alpha};
				`IDX_FILL_CTRL:  next_st.rdata = {30'h00000000, st.fill_ctrl};
				`IDX_EFF_SIZE:   next_st.rdata = {3'h0, st.eff_height, 3'h0, st.eff_width};
				default: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rresp = `RESP_SLVERR;
				end
			endcase
		end
		if (next_st.fill_ctrl[`CTRL_FILL_BIT]) begin
			next_st.eff_width  = next_st.fill_ctrl[`CTRL_SIZE_BIT] ? `PATTERN_LARGE
				: `PATTERN_SMALL;
			next_st.eff_height = next_st.eff_width;
		end else begin
			next_st.eff_width  = next_st.win_width;
			next_st.eff_height = next_st.win_height;
		end
		// Ready flags from the coming state
		next_st.aw_ready = !next_st.aw_held && !next_st.bvalid;
		next_st.w_ready  = !next_st.w_held && !next_st.bvalid;
		next_st.ar_ready = !next_st.rvalid;
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st            <= '0;
			st.src2_width <= `RESET_FIELD13;
			st.dst_addr   <= `RESET_ADDR32;
			st.alpha      <= `RESET_ALPHA;
			st.fill_ctrl  <= `RESET_CTRL;
		end else begin
			st <= next_st;
		end
	end

	// ======================================================================
	// Alpha mixer
	assign mix_bus.alpha        = st.alpha;
	assign mix_bus.first_pixel  = first_source_pixel_i;
	assign mix_bus.second_pixel = second_source_pixel_i;

	alpha_mixer u_mixer (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.mix_port  (mix_bus.mixer)
	);

	// ======================================================================
	// Outputs
	assign s_axi_awready_o             = st.aw_ready;
	assign s_axi_wready_o              = st.w_ready;
	assign s_axi_bvalid_o              = st.bvalid;
	assign s_axi_bresp_o               = st.bresp;
	assign s_axi_arready_o             = st.ar_ready;
	assign s_axi_rvalid_o              = st.rvalid;
	assign s_axi_rdata_o               = st.rdata;
	assign s_axi_rresp_o               = st.rresp;
	assign blended_pixel_o             = mix_bus.mixed_pixel;
	assign second_source_image_width_o = st.src2_width;
	assign second_source_corner_x_o    = st.src2_x;
	assign second_source_corner_y_o    = st.src2_y;
	assign destination_start_address_o = st.dst_addr;
	assign destination_image_width_o   = st.dst_width;
	assign destination_corner_x_o      = st.dst_x;
	assign destination_corner_y_o      = st.dst_y;
	assign transfer_window_width_o     = st.eff_width;
	assign transfer_window_height_o    = st.eff_height;
	assign alpha_level_o               = st.alpha;

	// ======================================================================
	// Checks
	a_src2_width_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(have_aw && have_w && !st.bvalid && wr_idx == `IDX_SRC2_WIDTH && wr_strb == 4'hf)
		|=> st.src2_width == ($past(wr_data[12:0]) & 13'h1ffc))
		else $error("second source width write wrong");
	a_src2_corner_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(have_aw && have_w && !st.bvalid && wr_idx == `IDX_SRC2_X && wr_strb == 4'h3)
		|=> st.src2_x == $past(wr_data[12:0]))
		else $error("second source corner write wrong");
	a_dst_addr_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(have_aw && have_w && !st.bvalid && wr_idx == `IDX_DST_ADDR && wr_strb == 4'hf)
		|=> st.dst_addr == {$past(wr_data[31:2]), 2'b00})
		else $error("destination address write wrong");
	a_dst_width_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		st.rvalid && $past(ar_fire && rd_idx == `IDX_DST_WIDTH) |-> st.rdata[1:0] == 2'b00
		&& st.rdata[31:13] == 19'h0)
		else $error("destination width low bits not zero");
	a_dst_corner_keep: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!(have_aw && have_w && !st.bvalid && wr_idx == `IDX_DST_Y) |=> $stable(st.dst_y))
		else $error("destination corner changed without write");
	a_win_width_eff: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!st.fill_ctrl[`CTRL_FILL_BIT] |-> st.eff_width == st.win_width)
		else $error("window width not passed through");
	a_win_height_eff: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!st.fill_ctrl[`CTRL_FILL_BIT] |-> st.eff_height == st.win_height)
		else $error("window height not passed through");
	a_pattern_size: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		st.fill_ctrl[`CTRL_FILL_BIT] |-> st.eff_width == (st.fill_ctrl[`CTRL_SIZE_BIT]
		? 13'h0010 : 13'h0008) && st.eff_height == st.eff_width)
		else $error("pattern fill size wrong");
	a_alpha_read_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		st.rvalid && $past(ar_fire && rd_idx == `IDX_ALPHA) |-> st.rdata[31:6] == 26'h0
		&& st.rdata[5:0] == $past(st.alpha))
		else $error("alpha read back wrong");

endmodule
`default_nettype wire

// ### rtl/blit_geometry_alpha_defs.svh
// Offsets, field masks, reset values and fixed sizes of the blit parameter registers
`ifndef BLIT_GEOMETRY_ALPHA_DEFS_SVH
`define BLIT_GEOMETRY_ALPHA_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_SRC2_WIDTH   10'h0a1
`define IDX_SRC2_X       10'h0a3
`define IDX_SRC2_Y       10'h0a5
`define IDX_DST_ADDR     10'h0a7
`define IDX_DST_WIDTH    10'h0ab
`define IDX_DST_X        10'h0ad
`define IDX_DST_Y        10'h0af
`define IDX_WIN_WIDTH    10'h0b1
`define IDX_WIN_HEIGHT   10'h0b3
`define IDX_ALPHA        10'h0b5
`define IDX_FILL_CTRL    10'h0c0
`define IDX_EFF_SIZE     10'h0c1

// ==========================================================================
// Field masks and positions
`define MASK_WIDTH       13'h1ffc
`define MASK_COORD       13'h1fff
`define MASK_ADDR        32'hffff_fffc
`define MASK_ALPHA       6'h3f
`define MASK_CTRL        2'h3
`define ALPHA_FULL_BIT   5
`define CTRL_FILL_BIT    0
`define CTRL_SIZE_BIT    1
`define EFF_HEIGHT_LSB   16

// ==========================================================================
// Reset values, fixed sizes, bus answers
`define RESET_FIELD13    13'h0000
`define RESET_ADDR32     32'h0000_0000
`define RESET_ALPHA      6'h00
`define RESET_CTRL       2'h0
`define PATTERN_SMALL    13'h0008
`define PATTERN_LARGE    13'h0010
`define ALPHA_ONE        6'h20
`define ALPHA_SHIFT      5
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ### rtl/blit_regs_pkg.sv
// Types shared by the blit parameter register bank and its alpha mixer
package blit_regs_pkg;

	// State of the register bank and its bus slave
	typedef struct packed {
		logic [12:0] src2_width;
		logic [12:0] src2_x;
		logic [12:0] src2_y;
		logic [31:0] dst_addr;
		logic [12:0] dst_width;
		logic [12:0] dst_x;
		logic [12:0] dst_y;
		logic [12:0] win_width;
		logic [12:0] win_height;
		logic [5:0]  alpha;
		logic [1:0]  fill_ctrl;
		logic [12:0] eff_width;
		logic [12:0] eff_height;
		logic        aw_held;
		logic [9:0]  aw_idx;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        aw_ready;
		logic        w_ready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_ready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} bank_s;

	// State of the alpha mixer
	typedef struct packed {
		logic [23:0] mix;
	} mixer_s;

endpackage

// ### rtl/alpha_mix_if.sv
// Carrier between the register bank and the alpha mixer
`timescale 1ns/1ps
`default_nettype none
interface alpha_mix_if;
	logic [5:0]  alpha;
	logic [23:0] first_pixel;
	logic [23:0] second_pixel;
	logic [23:0] mixed_pixel;

	modport bank  (output alpha, first_pixel, second_pixel, input mixed_pixel);
	modport mixer (input alpha, first_pixel, second_pixel, output mixed_pixel);
endinterface
`default_nettype wire

// ### rtl/alpha_mixer.sv
// Window alpha mixer of two sources, one cycle of latency
`timescale 1ns/1ps
`default_nettype none
`include "blit_geometry_alpha_defs.svh"
module alpha_mixer
	import blit_regs_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	alpha_mix_if.mixer      mix_port
);

	mixer_s      st;
	mixer_s      next_st;
	logic [23:0] weighted;
	logic [5:0]  first_weight;

	// ======================================================================
	// Weights
	// code to weight
	assign first_weight = `ALPHA_ONE - mix_port.alpha;

	// ======================================================================
	// Per channel mix
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
			logic [13:0] sum;
			assign sum = 14'(mix_port.first_pixel[ch*8 +: 8] * first_weight)
				+ 14'(mix_port.second_pixel[ch*8 +: 8] * mix_port.alpha);
			assign weighted[ch*8 +: 8] = sum[`ALPHA_SHIFT +: 8];
		end
	endgenerate

	// Next mix value
	always_comb begin
		next_st = st;
		if (mix_port.alpha[`ALPHA_FULL_BIT]) begin
			next_st.mix = mix_port.second_pixel;
		end else begin
			next_st.mix = weighted;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign mix_port.mixed_pixel = st.mix;

	// ======================================================================
	// Checks
	a_alpha_full_pass: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		mix_port.alpha[`ALPHA_FULL_BIT] |=> st.mix == $past(mix_port.second_pixel))
		else $error("full alpha did not pass second source");
	a_alpha_zero_pass: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		mix_port.alpha == 6'h00 |=> st.mix == $past(mix_port.first_pixel))
		else $error("zero alpha did not pass first source");
	a_alpha_half_mix: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(mix_port.alpha == 6'h10 && mix_port.first_pixel == 24'h000000
		&& mix_port.second_pixel == 24'hfefefe) |=> st.mix == 24'h7f7f7f)
		else $error("half alpha mix wrong");

endmodule
`default_nettype wire

// ### tb/test_blit_geometry_alpha_regs.sv
// Self-checking testbench of the blit geometry and window alpha register bank
`timescale 1ns/1ps
`default_nettype none
`include "blit_geometry_alpha_defs.svh"
module test_blit_geometry_alpha_regs;
	// ======================================================================
	// Signals and register table
	localparam int limit = 20000;
	localparam int nreg  = 11;
	localparam logic [11:0] reg_addr [nreg] = '{{`IDX_SRC2_WIDTH, 2'b00}, {`IDX_SRC2_X, 2'b00},
		{`IDX_SRC2_Y, 2'b00}, {`IDX_DST_ADDR, 2'b00}, {`IDX_DST_WIDTH, 2'b00},
		{`IDX_DST_X, 2'b00}, {`IDX_DST_Y, 2'b00}, {`IDX_WIN_WIDTH, 2'b00},
		{`IDX_WIN_HEIGHT, 2'b00}, {`IDX_ALPHA, 2'b00}, {`IDX_FILL_CTRL, 2'b00}};
	localparam logic [31:0] reg_mask [nreg] = '{32'h0000_1ffc, 32'h0000_1fff, 32'h0000_1fff,
		32'hffff_fffc, 32'h0000_1ffc, 32'h0000_1fff, 32'h0000_1fff, 32'h0000_1fff,
		32'h0000_1fff, 32'h0000_003f, 32'h0000_0003};
	localparam logic [11:0] eff_addr = {`IDX_EFF_SIZE, 2'b00};
	logic        sys_clk;
	logic        sys_rst;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [23:0] pix0;
	logic [23:0] pix1;
	logic [23:0] blended;
	logic [12:0] src2_w;
	logic [12:0] src2_x;
	logic [12:0] src2_y;
	logic [31:0] dst_addr;
	logic [12:0] dst_w;
	logic [12:0] dst_x;
	logic [12:0] dst_y;
	logic [12:0] win_w;
	logic [12:0] win_h;
	logic [5:0]  alpha;
	logic [31:0] model [nreg];
	int          err_count;
	int          checks_done;
	int          cycles;

	blit_geometry_alpha_regs blit_geometry_alpha_regs_inst (
		.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.first_source_pixel_i(pix0), .second_source_pixel_i(pix1), .blended_pixel_o(blended),
		.second_source_image_width_o(src2_w), .second_source_corner_x_o(src2_x),
		.second_source_corner_y_o(src2_y), .destination_start_address_o(dst_addr),
		.destination_image_width_o(dst_w), .destination_corner_x_o(dst_x),
		.destination_corner_y_o(dst_y), .transfer_window_width_o(win_w),
		.transfer_window_height_o(win_h), .alpha_level_o(alpha));

	// ======================================================================
	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == limit) begin
			err_count++;
			final_report();
		end
	end

	// ======================================================================
	// Expectation functions
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s,
		logic [31:0] m);
		for (int k = 0; k < 4; k++) begin
			if (s[k]) old[8*k +: 8] = d[8*k +: 8];
		end
		return old & m;
	endfunction

	function automatic logic [12:0] eff_size(int i);
		if (model[10][0]) return model[10][1] ? `PATTERN_LARGE : `PATTERN_SMALL;
		return model[i][12:0];
	endfunction

	function automatic logic [23:0] mix_exp(logic [5:0] a, logic [23:0] x, logic [23:0] y);
		logic [23:0] r;
		for (int k = 0; k < 3; k++) begin
			if (a[5]) r[8*k +: 8] = y[8*k +: 8];
			else r[8*k +: 8] = 8'((int'(x[8*k +: 8]) * (32 - int'(a))
				+ int'(y[8*k +: 8]) * int'(a)) >> 5);
		end
		return r;
	endfunction

	function automatic logic [31:0] port_val(int i);
		case (i)
			0: return {19'h0, src2_w};
			1: return {19'h0, src2_x};
			2: return {19'h0, src2_y};
			3: return dst_addr;
			4: return {19'h0, dst_w};
			5: return {19'h0, dst_x};
			6: return {19'h0, dst_y};
			7: return {19'h0, win_w};
			8: return {19'h0, win_h};
			default: return {26'h0, alpha};
		endcase
	endfunction

	// ======================================================================
	// Bus tasks and comparison
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, e, s);
		end
	endtask

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		bit aw_done;
		bit w_done;
		bit got;
		aw_done = 0;
		w_done = 0;
		got = 0;
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(posedge sys_clk);
			if (!aw_done && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_done = 1;
			end
			if (!w_done && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_done = 1;
			end
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				got = 1;
			end
		end
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit got;
		got = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(posedge sys_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				got = 1;
			end
		end
	endtask

	// Read one register back and compare its output port
	task automatic check_one(input int i);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(reg_addr[i], d, r);
		chk("register read", model[i], d);
		chk("read resp", {30'h0, `RESP_OKAY}, r);
		if (i < 10) chk("port", (i == 7 || i == 8) ? {19'h0, eff_size(i)} : model[i],
			port_val(i));
		axi_read(eff_addr, d, r);
		chk("effective size", {3'h0, eff_size(8), 3'h0, eff_size(7)}, d);
	endtask

	task automatic check_all(input string name);
		for (int i = 0; i < nreg; i++) check_one(i);
		$display("test %s done, errors %0d", name, err_count);
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [3:0]  s;
		logic [1:0]  r;
		logic [23:0] p0;
		logic [23:0] p1;
		logic [11:0] ua;
		int          i;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, pix0, pix1} = '0;
		{err_count, checks_done, cycles} = '0;
		foreach (model[k]) model[k] = 32'h0;
		sys_rst = 1'b1;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		void'($urandom(87));
		check_all("reset values");
		// All ones first, then random values and byte strobes
		for (int n = 0; n < 180; n++) begin
			i = (n < nreg) ? n : (n == nreg) ? 1 : $urandom_range(0, nreg - 1);
			d = (n < nreg) ? 32'hffff_ffff : $urandom;
			s = (n < nreg) ? 4'hf : (n == nreg) ? 4'h3 : 4'($urandom);
			// widths kept a multiple of four after the all-ones pass
			if (n >= nreg && (i == 0 || i == 4)) d[1:0] = 2'b00;
			// destination kept in upper memory, clear of the source areas
			if (n >= nreg && i == 3) d[31] = 1'b1;
			axi_write(reg_addr[i], d, s, r);
			chk("write resp", {30'h0, `RESP_OKAY}, r);
			model[i] = merge(model[i], d, s, reg_mask[i]);
			check_one(i);
		end
		check_all("random writes");
		// Unmapped places refuse, effective size ignores writes
		foreach (reg_addr[k]) begin
			if (k < 4) begin
				ua = (k == 0) ? 12'h288 : (k == 1) ? 12'h000 : (k == 2) ? 12'hffc : 12'h308;
				axi_write(ua, 32'hffff_ffff, 4'hf, r);
				chk("unmapped write", {30'h0, `RESP_SLVERR}, r);
				axi_read(ua, d, r);
				chk("unmapped resp", {30'h0, `RESP_SLVERR}, r);
				chk("unmapped data", 32'h0, d);
			end
		end
		axi_write(eff_addr, 32'hffff_ffff, 4'hf, r);
		chk("size write resp", {30'h0, `RESP_OKAY}, r);
		check_all("refused writes");
		// Every alpha code with mixed pixels
		for (int c = 0; c < 64; c++) begin
			axi_write({`IDX_ALPHA, 2'b00}, 32'(c), 4'h1, r);
			model[9] = 32'(c);
			chk("alpha port", model[9], port_val(9));
			// Half alpha on a dark and a near-white pixel
			p0 = (c == 16) ? 24'h000000 : (c % 8 == 0) ? 24'hffffff : 24'($urandom);
			p1 = (c == 16) ? 24'hfefefe : (c % 8 == 1) ? 24'hffffff : 24'($urandom);
			@(posedge sys_clk);
			pix0 <= p0;
			pix1 <= p1;
			@(posedge sys_clk);
			#1;
			chk("blended", {8'h0, mix_exp(6'(c), p0, p1)}, {8'h0, blended});
		end
		$display("test alpha codes done, errors %0d", err_count);
		// Reset in mid-run clears everything
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		foreach (model[k]) model[k] = 32'h0;
		check_all("second reset");
		final_report();
	end
endmodule
`default_nettype wire
